// [core/tc_tone_control.sv]
// Tone control: headroom attenuation, bass and treble shelving, byte registers
`timescale 1ns/10ps
`default_nettype none
`include "tc_map.svh"
module tc_tone_control (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               soft_reset,
    input  wire logic [7:0]         reg_addr,
    input  wire logic               reg_we,
    input  wire logic [7:0]         reg_wdata,
    output logic      [7:0]         reg_rdata,
    input  wire logic [15:0]        sample_rate_hz,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire tc_pkg::tc_sample_t in_sample,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output tc_pkg::tc_sample_t      out_sample
);
    logic [7:0]  treble_gain;
    logic [7:0]  next_treble_gain;
    logic [7:0]  bass_gain;
    logic [7:0]  next_bass_gain;
    logic [7:0]  headroom_attenuation;
    logic [7:0]  next_headroom_attenuation;
    logic [15:0] treble_corner;
    logic [15:0] next_treble_corner;
    logic [15:0] bass_corner;
    logic [15:0] next_bass_corner;
    logic [7:0]  next_reg_rdata;
    logic        corner_write;

    always_comb begin
        next_treble_gain          = treble_gain;
        next_bass_gain            = bass_gain;
        next_headroom_attenuation = headroom_attenuation;
        next_treble_corner        = treble_corner;
        next_bass_corner          = bass_corner;
        corner_write              = 1'b0;
        if (soft_reset) begin
            next_treble_gain          = `TC_RESET_BYTE; // R9
            next_bass_gain            = `TC_RESET_BYTE; // R9
            next_headroom_attenuation = `TC_RESET_BYTE; // R9
            next_treble_corner        = `TC_RESET_WORD;
            next_bass_corner          = `TC_RESET_WORD;
        end else if (reg_we) begin
            case (reg_addr)
                `TC_ADDR_TREBLE_FREQ_LO: begin
                    next_treble_corner[7:0] = reg_wdata; // R10
                    corner_write            = 1'b1;
                end
                `TC_ADDR_TREBLE_FREQ_HI: begin
                    next_treble_corner[15:8] = reg_wdata; // R10
                    corner_write             = 1'b1;
                end
                `TC_ADDR_BASS_FREQ_LO: begin
                    next_bass_corner[7:0] = reg_wdata; // R11
                    corner_write          = 1'b1;
                end
                `TC_ADDR_BASS_FREQ_HI: begin
                    next_bass_corner[15:8] = reg_wdata; // R11
                    corner_write           = 1'b1;
                end
                `TC_ADDR_TREBLE_GAIN: next_treble_gain = reg_wdata;
                `TC_ADDR_BASS_GAIN:   next_bass_gain = reg_wdata;
                `TC_ADDR_HEADROOM:    next_headroom_attenuation = reg_wdata;
                default: ;
            endcase
        end
        case (reg_addr)
            `TC_ADDR_TREBLE_FREQ_LO: next_reg_rdata = treble_corner[7:0];
            `TC_ADDR_TREBLE_FREQ_HI: next_reg_rdata = treble_corner[15:8];
            `TC_ADDR_BASS_FREQ_LO:   next_reg_rdata = bass_corner[7:0];
            `TC_ADDR_BASS_FREQ_HI:   next_reg_rdata = bass_corner[15:8];
            `TC_ADDR_TREBLE_GAIN:    next_reg_rdata = treble_gain;
            `TC_ADDR_BASS_GAIN:      next_reg_rdata = bass_gain;
            `TC_ADDR_HEADROOM:       next_reg_rdata = headroom_attenuation;
            default:                 next_reg_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            treble_gain          <= `TC_RESET_BYTE; // R9
            bass_gain            <= `TC_RESET_BYTE; // R9
            headroom_attenuation <= `TC_RESET_BYTE; // R9
            treble_corner        <= `TC_RESET_WORD;
            bass_corner          <= `TC_RESET_WORD;
            reg_rdata            <= 8'h00;
        end else begin
            treble_gain          <= next_treble_gain;
            bass_gain            <= next_bass_gain;
            headroom_attenuation <= next_headroom_attenuation;
            treble_corner        <= next_treble_corner;
            bass_corner          <= next_bass_corner;
            reg_rdata            <= next_reg_rdata;
        end
    end

    // Index 12 is unity; each step away is 1.5 dB, gain in Q4.12
    function automatic logic [15:0] tc_gain(input logic [4:0] idx);
        case (idx)
            5'h00: tc_gain = 16'h0204;
            5'h01: tc_gain = 16'h0265;
            5'h02: tc_gain = 16'h02d8;
            5'h03: tc_gain = 16'h0362;
            5'h04: tc_gain = 16'h0405;
            5'h05: tc_gain = 16'h04c7;
            5'h06: tc_gain = 16'h05ad;
            5'h07: tc_gain = 16'h06bf;
            5'h08: tc_gain = 16'h0805;
            5'h09: tc_gain = 16'h0988;
            5'h0a: tc_gain = 16'h0b54;
            5'h0b: tc_gain = 16'h0d76;
            5'h0d: tc_gain = 16'h1304;
            5'h0e: tc_gain = 16'h169a;
            5'h0f: tc_gain = 16'h1adc;
            5'h10: tc_gain = 16'h1fed;
            5'h11: tc_gain = 16'h25f1;
            5'h12: tc_gain = 16'h2d18;
            5'h13: tc_gain = 16'h3598;
            5'h14: tc_gain = 16'h3fb2;
            5'h15: tc_gain = 16'h4bb4;
            5'h16: tc_gain = 16'h59fa;
            5'h17: tc_gain = 16'h6aef;
            5'h18: tc_gain = 16'h7f18;
            default: tc_gain = 16'h1000;
        endcase
    endfunction

    // Out-of-range codes are clamped so a bad write cannot exceed +-18 dB
    function automatic logic [4:0] tc_tone_index(input logic [7:0] code);
        if ($signed(code) > $signed(`TC_CODE_MAX)) begin
            tc_tone_index = `TC_INDEX_TOP; // R5
        end else if ($signed(code) < $signed(`TC_CODE_MIN)) begin
            tc_tone_index = 5'h00; // R5
        end else begin
            tc_tone_index = code[4:0] + `TC_INDEX_MID; // R3 R4
        end
    endfunction

    logic [15:0]        gain_att;
    logic signed [16:0] delta_bass;
    logic signed [16:0] delta_treble;

    always_comb begin
        if (headroom_attenuation > `TC_CODE_MAX) begin
            gain_att = tc_gain(5'h00); // R6
        end else begin
            gain_att = tc_gain(`TC_INDEX_MID - headroom_attenuation[4:0]); // R6 R7
        end
        delta_bass   = $signed({1'b0, tc_gain(tc_tone_index(bass_gain))}) - `TC_UNITY_GAIN; // R2
        delta_treble = $signed({1'b0, tc_gain(tc_tone_index(treble_gain))}) - `TC_UNITY_GAIN; // R1
    end

    // alpha = 2*pi*fc/Fs in Q0.16, by a serial divider, so no wide divider sits in the path
    tc_pkg::tc_coef_state_t coef_state;
    tc_pkg::tc_coef_state_t next_coef_state;
    logic        coef_sel;
    logic        next_coef_sel;
    logic        coef_dirty;
    logic        next_coef_dirty;
    logic [5:0]  div_cnt;
    logic [5:0]  next_div_cnt;
    logic [34:0] div_num;
    logic [34:0] next_div_num;
    logic [16:0] div_rem;
    logic [16:0] next_div_rem;
    logic [15:0] alpha_bass;
    logic [15:0] next_alpha_bass;
    logic [15:0] alpha_treble;
    logic [15:0] next_alpha_treble;
    logic [15:0] rate_seen;
    logic [17:0] trial;
    logic [15:0] quot;

    always_comb begin
        next_coef_state   = coef_state;
        next_coef_sel     = coef_sel;
        next_div_cnt      = div_cnt;
        next_div_num      = div_num;
        next_div_rem      = div_rem;
        next_alpha_bass   = alpha_bass;
        next_alpha_treble = alpha_treble;
        next_coef_dirty   = coef_dirty;
        trial             = {div_rem, div_num[34]} - {2'b00, sample_rate_hz};
        quot              = (div_num[33:16] != '0) ? `TC_ALPHA_MAX : {div_num[14:0], ~trial[17]};
        case (coef_state)
            tc_pkg::TC_C_IDLE: begin
                if (coef_dirty) begin
                    next_coef_dirty = 1'b0;
                    next_coef_sel   = 1'b0;
                    next_div_cnt    = 6'h00;
                    next_div_rem    = 17'h00000;
                    next_div_num    = bass_corner * `TC_TWO_PI_Q16; // R11
                    next_coef_state = tc_pkg::TC_C_RUN;
                end
            end
            tc_pkg::TC_C_RUN: begin
                next_div_cnt = div_cnt + 6'h01;
                if (!trial[17]) begin
                    next_div_rem = trial[16:0];
                end else begin
                    next_div_rem = {div_rem[15:0], div_num[34]};
                end
                next_div_num = {div_num[33:0], ~trial[17]};
                if (div_cnt == `TC_DIV_LAST) begin
                    next_div_cnt = 6'h00;
                    next_div_rem = 17'h00000;
                    if (!coef_sel) begin
                        next_alpha_bass = (sample_rate_hz == '0) ? 16'h0000 : quot;
                        next_coef_sel   = 1'b1;
                        next_div_num    = treble_corner * `TC_TWO_PI_Q16; // R10
                    end else begin
                        next_alpha_treble = (sample_rate_hz == '0) ? 16'h0000 : quot;
                        next_coef_state   = tc_pkg::TC_C_IDLE;
                    end
                end
            end
            default: next_coef_state = tc_pkg::TC_C_IDLE;
        endcase
        // A change landing during a run forces one more pass
        if (corner_write || soft_reset || sample_rate_hz != rate_seen) begin
            next_coef_dirty = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            coef_state   <= tc_pkg::TC_C_IDLE;
            coef_sel     <= 1'b0;
            coef_dirty   <= 1'b1;
            div_cnt      <= 6'h00;
            div_num      <= 35'h0;
            div_rem      <= 17'h00000;
            alpha_bass   <= 16'h0000;
            alpha_treble <= 16'h0000;
            rate_seen    <= 16'h0000;
        end else begin
            coef_state   <= next_coef_state;
            coef_sel     <= next_coef_sel;
            coef_dirty   <= next_coef_dirty;
            div_cnt      <= next_div_cnt;
            div_num      <= next_div_num;
            div_rem      <= next_div_rem;
            alpha_bass   <= next_alpha_bass;
            alpha_treble <= next_alpha_treble;
            rate_seen    <= sample_rate_hz;
        end
    end

    tc_pkg::tc_state_t  state;
    tc_pkg::tc_state_t  next_state;
    tc_pkg::tc_sample_t buf_sample;
    logic               buf_valid;
    wire logic [`TC_CHANNELS-1:0][`TC_SAMPLE_W-1:0] out_bus;

    tc_fifo #(
        .WIDTH ($bits(tc_pkg::tc_sample_t)),
        .DEPTH (`TC_FIFO_DEPTH)
    ) u_in_fifo (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .flush    (soft_reset),
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .wr_data  (in_sample),
        .rd_valid (buf_valid),
        .rd_ready (state == tc_pkg::TC_ATT),
        .rd_data  (buf_sample)
    );

    always_comb begin
        next_state = state;
        case (state)
            tc_pkg::TC_IDLE:  next_state = buf_valid ? tc_pkg::TC_ATT : tc_pkg::TC_IDLE;
            tc_pkg::TC_ATT:   next_state = tc_pkg::TC_SHAPE;
            tc_pkg::TC_SHAPE: next_state = tc_pkg::TC_MIX;
            tc_pkg::TC_MIX:   next_state = tc_pkg::TC_HOLD;
            tc_pkg::TC_HOLD:  next_state = out_ready ? tc_pkg::TC_IDLE : tc_pkg::TC_HOLD;
            default:          next_state = tc_pkg::TC_IDLE;
        endcase
        if (soft_reset) begin
            next_state = tc_pkg::TC_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= tc_pkg::TC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign out_valid  = (state == tc_pkg::TC_HOLD);
    assign out_sample = tc_pkg::tc_sample_t'(out_bus);

    for (genvar c = 0; c < `TC_CHANNELS; c++) begin : g_ch
        logic signed [15:0] att_s;
        logic signed [15:0] next_att_s;
        logic signed [23:0] lp_bass;
        logic signed [23:0] next_lp_bass;
        logic signed [23:0] lp_treble;
        logic signed [23:0] next_lp_treble;
        logic signed [15:0] mix_out;
        logic signed [15:0] next_mix_out;
        logic signed [32:0] att_prod;
        logic signed [24:0] diff_b;
        logic signed [24:0] diff_t;
        logic signed [41:0] step_b;
        logic signed [41:0] step_t;
        logic signed [24:0] sum_b;
        logic signed [24:0] sum_t;
        logic signed [16:0] high_s;
        logic signed [32:0] boost_b;
        logic signed [33:0] boost_t;
        logic signed [23:0] mix_sum;

        always_comb begin
            att_prod = $signed(buf_sample.ch[c]) * $signed({1'b0, gain_att}); // R6 R13
            diff_b   = $signed({att_s[15], att_s, 8'h00}) - $signed({lp_bass[23], lp_bass});
            diff_t   = $signed({att_s[15], att_s, 8'h00}) - $signed({lp_treble[23], lp_treble});
            step_b   = diff_b * $signed({1'b0, alpha_bass});
            step_t   = diff_t * $signed({1'b0, alpha_treble});
            sum_b    = $signed({lp_bass[23], lp_bass}) + step_b[40:16];
            sum_t    = $signed({lp_treble[23], lp_treble}) + step_t[40:16];
            high_s   = $signed({att_s[15], att_s}) - $signed({lp_treble[23], lp_treble[23:8]});
            boost_b  = delta_bass * $signed(lp_bass[23:8]); // R2
            boost_t  = delta_treble * high_s; // R1
            mix_sum  = $signed({{8{att_s[15]}}, att_s}) + $signed({{3{boost_b[32]}}, boost_b[32:12]})
                     + $signed({{2{boost_t[33]}}, boost_t[33:12]});
            next_att_s     = att_s;
            next_lp_bass   = lp_bass;
            next_lp_treble = lp_treble;
            next_mix_out   = mix_out;
            if (soft_reset) begin
                next_att_s     = 16'sh0000;
                next_lp_bass   = 24'sh000000;
                next_lp_treble = 24'sh000000;
                next_mix_out   = 16'sh0000;
            end else begin
                case (state)
                    tc_pkg::TC_ATT: next_att_s = att_prod[27:12]; // R6
                    tc_pkg::TC_SHAPE: begin
                        next_lp_bass   = sum_b[23:0]; // R11
                        next_lp_treble = sum_t[23:0]; // R10
                    end
                    tc_pkg::TC_MIX: begin
                        if (mix_sum > $signed({{8{1'b0}}, `TC_SAT_POS})) begin
                            next_mix_out = `TC_SAT_POS; // R14
                        end else if (mix_sum < $signed({{8{1'b1}}, `TC_SAT_NEG})) begin
                            next_mix_out = `TC_SAT_NEG; // R14
                        end else begin
                            next_mix_out = mix_sum[15:0]; // R13
                        end
                    end
                    default: ;
                endcase
            end
        end

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                att_s     <= 16'sh0000;
                lp_bass   <= 24'sh000000;
                lp_treble <= 24'sh000000;
                mix_out   <= 16'sh0000;
            end else begin
                att_s     <= next_att_s;
                lp_bass   <= next_lp_bass;
                lp_treble <= next_lp_treble;
                mix_out   <= next_mix_out;
            end
        end

        assign out_bus[c] = mix_out;
    end
endmodule // tc_tone_control
`default_nettype wire

// [pkg/tc_map.svh]
// Register map, reset values and fixed-point constants of the tone control
// Summary of operation
// R1: Treble gain code boosts or cuts the treble band.
// R2: Bass gain code boosts or cuts the bass band.
// R3: Gains are 8-bit signed codes: zero flat, positive boost, negative cut.
// R4: Each gain code unit is one 1.5 dB step of boost or cut.
// R5: Gains span -18 dB to +18 dB, codes -12 to +12; host stays inside.
// R6: Headroom code attenuates 1.5 dB per unit, zero is 0 dB, down to -18 dB.
// R7: 0 dB attenuation is full scale, so unattenuated boost would overflow.
// R8: Host sets headroom attenuation at least equal to the largest boost used.
// R9: Gain and headroom registers clear on hardware and software reset.
// R10: Two-byte treble corner in hertz sets the treble shelf.
// R11: Two-byte bass corner in hertz sets the bass shelf.
// R12: Host keeps treble corner below Fs/2 and bass corner in (0, treble corner].
// R13: Attenuation then bass and treble shaping apply alike to both channels.
// R14: Shaped samples beyond full scale saturate instead of wrapping.
`ifndef TC_MAP_SVH
`define TC_MAP_SVH

`define TC_ADDR_TREBLE_FREQ_LO  8'h77
`define TC_ADDR_TREBLE_FREQ_HI  8'h78
`define TC_ADDR_BASS_FREQ_LO    8'h79
`define TC_ADDR_BASS_FREQ_HI    8'h7a
`define TC_ADDR_TREBLE_GAIN     8'h7b
`define TC_ADDR_BASS_GAIN       8'h7c
`define TC_ADDR_HEADROOM        8'h7d

`define TC_RESET_BYTE           8'h00
`define TC_RESET_WORD           16'h0000

`define TC_CHANNELS             2
`define TC_SAMPLE_W             16
`define TC_FIFO_DEPTH           16

`define TC_CODE_MAX             8'h0c
`define TC_CODE_MIN             8'hf4
`define TC_INDEX_MID            5'h0c
`define TC_INDEX_TOP            5'h18

`define TC_UNITY_GAIN           17'sh01000
`define TC_TWO_PI_Q16           19'h6487f
`define TC_DIV_LAST             6'h22
`define TC_ALPHA_MAX            16'hffff
`define TC_SAT_POS              16'sh7fff
`define TC_SAT_NEG              16'sh8000

`endif

// [pkg/tc_pkg.sv]
// Types shared by the tone control stage and its sample buffer
package tc_pkg;

    typedef struct packed {
        logic [1:0][15:0] ch;
    } tc_sample_t;

    typedef enum logic [2:0] {
        TC_IDLE,
        TC_ATT,
        TC_SHAPE,
        TC_MIX,
        TC_HOLD
    } tc_state_t;

    typedef enum logic [1:0] {
        TC_C_IDLE,
        TC_C_RUN
    } tc_coef_state_t;

endpackage

// [core/tc_fifo.sv]
// Sample buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module tc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign wr_ready = (count != DEPTH[AW:0]);
    assign rd_valid = (count != '0);
    assign rd_data  = mem[rd_ptr];
    assign push     = wr_valid & wr_ready & ~flush;
    assign pop      = rd_valid & rd_ready & ~flush;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = '0;
        end else begin
            if (push) begin
                next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                next_count = count + 1'b1;
            end else if (pop && !push) begin
                next_count = count - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage has no reset; the pointers say what is valid
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= wr_data;
        end
    end
endmodule // tc_fifo
`default_nettype wire

// [sim/tc_tone_control_chk.sv]
// Port checks of the tone control
`timescale 1ns/10ps
`default_nettype none
module tc_tone_control_chk (
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire logic               soft_reset,
    input wire logic [7:0]         reg_addr,
    input wire logic               reg_we,
    input wire logic [7:0]         reg_wdata,
    input wire logic [7:0]         reg_rdata,
    input wire logic [15:0]        sample_rate_hz,
    input wire logic               in_valid,
    input wire logic               in_ready,
    input wire tc_pkg::tc_sample_t in_sample,
    input wire logic               out_valid,
    input wire logic               out_ready,
    input wire tc_pkg::tc_sample_t out_sample
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rdback;
        reg_we && !soft_reset && reg_addr inside {[8'h77:8'h7d]} ##1
        !reg_we && !soft_reset && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_rdback: assert property (p_rdback) else $error("readback differs");
    property p_unmap;
        !(reg_addr inside {[8'h77:8'h7d]}) |=> reg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_soft;
        soft_reset ##1 !reg_we && $stable(reg_addr) |=> reg_rdata == 8'h00;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset kept a value");
    property p_hold;
        out_valid && !out_ready && !soft_reset |=> out_valid && $stable(out_sample);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled output moved");
    property p_drop;
        out_valid && out_ready |=> !out_valid;
    endproperty
    a_drop: assert property (p_drop) else $error("output stayed after accept");
    property p_answer;
        disable iff (!rst_n || soft_reset) in_valid && in_ready |-> ##[5:400] out_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("sample lost");
    property p_rst;
        disable iff (1'b0) !rst_n |-> in_ready && !out_valid && reg_rdata == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs wrong in reset");
    property p_first;
        disable iff (1'b0) $rose(rst_n) |-> !out_valid && out_sample == '0;
    endproperty
    a_first: assert property (p_first) else $error("output set after reset");
    property p_full;
        $fell(in_ready) |-> $past(in_valid);
    endproperty
    a_full: assert property (p_full) else $error("buffer filled without input");
    c_out: cover property (out_valid && out_ready);
    c_full: cover property (in_valid && !in_ready);
    c_soft: cover property (soft_reset ##1 !soft_reset);
endmodule // tc_tone_control_chk
bind tc_tone_control tc_tone_control_chk chk (.*);
`default_nettype wire

// [sim/tc_host.sv]
// Host model that programs the tone control registers
`timescale 1ns/10ps
`default_nettype none
module tc_host (
    input  wire logic       ref_clk,
    output logic      [7:0] reg_addr,
    output logic            reg_we,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial {reg_addr, reg_we, reg_wdata} = 17'h00000;
    // One idle edge after each write keeps the strobe a clean pulse
    task automatic wr(input logic [7:0] a, dat);
        @(negedge ref_clk);
        reg_addr = a;
        reg_we = 1'b1;
        reg_wdata = dat;
        @(negedge ref_clk);
        reg_we = 1'b0;
        reg_wdata = ~dat;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(negedge ref_clk);
        reg_addr = a;
        @(negedge ref_clk);
        dat = reg_rdata;
    endtask
    // Margin goes in before any boost
    task automatic tone(input int att, b, t);
        if (b >= -12 && b <= 12 && t >= -12 && t <= 12) begin
            wr(8'h7d, 8'(att > b ? (att > t ? att : t) : (b > t ? b : t)));
            wr(8'h7c, 8'(b));
            wr(8'h7b, 8'(t));
        end
    endtask
    task automatic corners(input int tf, bf, fs);
        if (bf > 0 && bf <= tf && 2 * tf < fs) begin
            wr(8'h77, 8'(tf));
            wr(8'h78, 8'(tf >> 8));
            wr(8'h79, 8'(bf));
            wr(8'h7a, 8'(bf >> 8));
        end
    endtask
endmodule // tc_host
`default_nettype wire

// [sim/tc_tone_control_tb.sv]
// Self-checking bench of the tone control
`timescale 1ns/10ps
`default_nettype none
module tc_tone_control_tb;
    logic               ref_clk = 1'b0, rst_n = 1'b0, soft_reset = 1'b0;
    logic [7:0]         reg_addr, reg_wdata, reg_rdata, d;
    logic               reg_we, in_ready, out_valid, in_valid = 1'b0, out_ready = 1'b1;
    logic [15:0]        sample_rate_hz = 16'h03e8;
    tc_pkg::tc_sample_t in_sample = '0, out_sample, q[$];
    int                 num_errors = 0, total_checks = 0, g;
    always #12.5 ref_clk = ~ref_clk;
    tc_tone_control dut (.*);
    tc_host host (.ref_clk, .reg_addr, .reg_we, .reg_wdata, .reg_rdata);
    task automatic check(input logic [31:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic rchk(input logic [7:0] a, exp);
        host.rd(a, d);
        check(d, exp, "register");
    endtask
    task automatic zeros();
        for (int a = 8'h77; a <= 8'h7e; a++) rchk(8'(a), 8'h00);
    endtask
    task automatic push(input logic [15:0] a, b, ea, eb);
        int n;
        @(negedge ref_clk);
        for (n = 0; !in_ready && n < 400; n++) begin
            in_valid = 1'b0;
            @(negedge ref_clk);
        end
        if (n == 400) begin
            num_errors++;
            conclude();
        end
        in_valid = 1'b1;
        in_sample = tc_pkg::tc_sample_t'({b, a});
        q.push_back(tc_pkg::tc_sample_t'({eb, ea}));
    endtask
    task automatic drain();
        int n;
        @(negedge ref_clk);
        in_valid = 1'b0;
        out_ready = 1'b1;
        for (n = 0; q.size() != 0 && n < 2000; n++) @(negedge ref_clk);
        if (n == 2000) begin
            num_errors++;
            conclude();
        end
    endtask
    always @(posedge ref_clk) begin
        if (rst_n && out_valid === 1'b1 && out_ready)
            check(out_sample, q.size() ? q.pop_front() : 32'hx, "sample");
    end
    initial begin
        void'($urandom(86));
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1'b1;
        zeros();
        // Flat settings must pass both channels untouched
        repeat (8) begin
            g = $urandom;
            push(g[15:0], g[31:16], g[15:0], g[31:16]);
        end
        drain();
        for (int k = 0; k <= 13; k++) begin
            g = $rtoi(4096.0 * 10.0 ** (-1.5 * (k > 12 ? 12 : k) / 20.0) + 0.5);
            host.tone(k, 0, 0);
            push(16'h1000, 16'hf000, g[15:0], 16'(-g));
            drain();
        end
        // No margin on purpose: full-band treble boost must clip
        host.tone(0, 0, 0);
        host.wr(8'h7b, 8'h0c);
        push(16'h2000, 16'he000, 16'h7fff, 16'h8000);
        drain();
        host.wr(8'h7b, 8'h00);
        host.corners(400, 150, 1000);
        rchk(8'h77, 8'h90);
        rchk(8'h79, 8'h96);
        repeat (100) @(negedge ref_clk);
        repeat (4) push(16'h2000, 16'he000, 16'h2000, 16'he000);
        drain();
        host.wr(8'h7c, 8'h0c);
        push(16'h2000, 16'he000, 16'h7fff, 16'h8000);
        drain();
        for (int a = 8'h77; a <= 8'h7e; a++) begin
            g = $urandom;
            host.wr(8'(a), g[7:0]);
            rchk(8'(a), a == 8'h7e ? 8'h00 : g[7:0]);
        end
        @(negedge ref_clk) soft_reset = 1'b1;
        @(negedge ref_clk) soft_reset = 1'b0;
        zeros();
        // Stalled consumer: 16 buffered plus one held, then refusal
        out_ready = 1'b0;
        repeat (17) begin
            g = $urandom;
            push(g[15:0], g[31:16], g[15:0], g[31:16]);
        end
        @(negedge ref_clk) in_valid = 1'b0;
        check(in_ready, 1'b0, "in_ready");
        drain();
        conclude();
    end
endmodule // tc_tone_control_tb
`default_nettype wire
